// >>> logic/mbist_consts.svh
`ifndef MBIST_CONSTS_SVH
`define MBIST_CONSTS_SVH

// Instruction register field holding the pattern code
`define MB_INSTR_W       56
`define MB_CODE_HI       55
`define MB_CODE_LO       50

// Array enable bus layout
`define MB_EN_W          18
`define MB_EN_LOW_WAYS   16
`define MB_EN_HIGH_WAYS  17

// Address and data bus shape
`define MB_ADDR_W        9
`define MB_CPUS          4
`define MB_SLOT_W        72
`define MB_BUS_W         288
`define MB_TAG_W_NOPAR   22
`define MB_TAG_W_PAR     25
`define MB_PAD_NOPAR     10
`define MB_PAD_PAR       11

// Cache size codes and their top address
`define MB_SIZE_16K      2'h0
`define MB_SIZE_32K      2'h1
`define MB_AMAX_16K      9'h07F
`define MB_AMAX_32K      9'h0FF
`define MB_AMAX_64K      9'h1FF

// Pattern codes
`define MB_PAT_SOLID_WR  6'h00
`define MB_PAT_SOLID_RD  6'h01
`define MB_PAT_CKBD_WR   6'h02
`define MB_PAT_CKBD_RD   6'h03
`define MB_PAT_MARCH_CP  6'h04
`define MB_PAT_FAULT     6'h05
`define MB_PAT_ROW_MARCH 6'h06
`define MB_PAT_COL_MARCH 6'h07
`define MB_PAT_WL_RWR    6'h08
`define MB_PAT_BL_RWR    6'h09
`define MB_PAT_HAMMER    6'h0A
`define MB_PAT_MARCH_CY  6'h0B
`define MB_PAT_GO_NOGO   6'h3F

// Element flags
`define MB_F_NONE        6'h00
`define MB_F_DOWN        6'h20
`define MB_F_INV         6'h10
`define MB_F_CKBD        6'h08
`define MB_F_YFAST       6'h04
`define MB_F_SEED5       6'h02
`define MB_F_INJECT      6'h01

// Misc values and timing
`define MB_SEED_GO       4'h5
`define MB_INJECT_NIB    4'hF
`define MB_LAST_RWR      3'h2
`define MB_LAST_RW       3'h1
`define MB_LAST_BANG     3'h7
`define MB_BANG_FIRST_RW 3'h2
`define MB_DRAIN_CYC     2'h2

`endif

// >>> logic/mbist_pkg.sv
package mbist_pkg;

   // Kind of a march element, i.e. the operations applied per location
   typedef enum logic [2:0] {
      el_end  = 3'b000,
      el_wr   = 3'b001,
      el_rd   = 3'b010,
      el_rwr  = 3'b011,
      el_rw   = 3'b100,
      el_bang = 3'b101
   } kind_e;

   // One march element of a pattern program
   typedef struct packed {
      kind_e kind;
      logic  down;
      logic  inv;
      logic  ckbd;
      logic  yfast;
      logic  seed5;
      logic  inject;
   } elem_s;

   // Static test configuration sampled at start
   typedef struct packed {
      logic [1:0] cache_size;
      logic       parity;
      logic       way_group;
      logic [3:0] seed;
   } cfg_s;

   // Engine sequencing states
   typedef enum logic [1:0] {
      st_idle  = 2'b00,
      st_init  = 2'b01,
      st_run   = 2'b10,
      st_drain = 2'b11
   } state_e;

endpackage : mbist_pkg

// >>> logic/mbist_addr_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "mbist_consts.svh"

// Maps the linear march counter onto the array address {row, col}.
// The column sits in the two low address bits.
module mbist_addr_gen (
   input  wire logic [`MB_ADDR_W-1:0] cnt,
   input  wire logic [1:0]            cache_size,
   input  wire logic                  yfast,
   output logic      [`MB_ADDR_W-1:0] addr
);

   // Row fast: low counter bits go to the row field for each size
   logic [`MB_ADDR_W-1:0] x_16k;   // 7-bit array
   logic [`MB_ADDR_W-1:0] x_32k;   // 8-bit array
   logic [`MB_ADDR_W-1:0] x_64k;   // 9-bit array
   logic [`MB_ADDR_W-1:0] x_sel;   // Chosen row-fast address

   assign x_16k = {2'h0, cnt[4:0], cnt[6:5]};
   assign x_32k = {1'h0, cnt[5:0], cnt[7:6]};
   assign x_64k = {cnt[6:0], cnt[8:7]};

   // Size decode; an unused size code is treated as the largest array
   assign x_sel = (cache_size == `MB_SIZE_16K) ? x_16k :
                  (cache_size == `MB_SIZE_32K) ? x_32k : x_64k;

   // Column fast is the counter itself, column in the low bits
   assign addr = yfast ? cnt : x_sel;

endmodule : mbist_addr_gen
`default_nettype wire

// >>> logic/mbist_pattern_engine.sv
`timescale 1ns/1ps
`default_nettype none
`include "mbist_consts.svh"
// Self-test pattern engine for the coherency unit tag arrays.
// A pattern is a short program of march elements; each element walks
// the whole address range and applies one to eight operations per location.
module mbist_pattern_engine (
   input  wire logic                   clk,
   input  wire logic                   reset,
   input  wire logic                   start,
   input  wire logic [`MB_INSTR_W-1:0] test_instr,
   input  wire mbist_pkg::cfg_s        cfg,
   input  wire logic [`MB_BUS_W-1:0]   test_read_data,
   output logic      [`MB_EN_W-1:0]    array_enable_bus,
   output logic      [`MB_ADDR_W-1:0]  test_address_bus,
   output logic      [`MB_BUS_W-1:0]   test_write_data,
   output logic                        test_write_en,
   output logic                        test_read_en,
   output logic                        busy,
   output logic                        done,
   output logic                        fail
);
   // Build one element from kind and flag bits
   function automatic mbist_pkg::elem_s mk(input mbist_pkg::kind_e k, input logic [5:0] f);
      mk = {k, f};
   endfunction : mk
   // Pattern programs; an index past the last element reads as the end marker
   function automatic mbist_pkg::elem_s prog(input logic [5:0] code, input logic [3:0] idx);
      logic [5:0] yf;
      yf   = ((code == `MB_PAT_COL_MARCH) || (code == `MB_PAT_BL_RWR)) ? `MB_F_YFAST : `MB_F_NONE;
      prog = mk(mbist_pkg::el_end, `MB_F_NONE);
      case (code)
         `MB_PAT_SOLID_WR: if (idx == 4'h0) prog = mk(mbist_pkg::el_wr, `MB_F_NONE);
         `MB_PAT_SOLID_RD: if (idx == 4'h0) prog = mk(mbist_pkg::el_rd, `MB_F_NONE);
         `MB_PAT_CKBD_WR:  if (idx == 4'h0) prog = mk(mbist_pkg::el_wr, `MB_F_CKBD);
         `MB_PAT_CKBD_RD:  if (idx == 4'h0) prog = mk(mbist_pkg::el_rd, `MB_F_CKBD);
         `MB_PAT_MARCH_CP: begin
            case (idx)
               4'h0:    prog = mk(mbist_pkg::el_wr, `MB_F_NONE);
               4'h1:    prog = mk(mbist_pkg::el_rwr, `MB_F_NONE);
               4'h2:    prog = mk(mbist_pkg::el_rwr, `MB_F_INV);
               4'h3:    prog = mk(mbist_pkg::el_rwr, `MB_F_DOWN);
               4'h4:    prog = mk(mbist_pkg::el_rwr, `MB_F_DOWN | `MB_F_INV);
               4'h5:    prog = mk(mbist_pkg::el_rd, `MB_F_DOWN);
               default: prog = mk(mbist_pkg::el_end, `MB_F_NONE);
            endcase
         end
         `MB_PAT_FAULT: begin
            case (idx)
               4'h0:    prog = mk(mbist_pkg::el_wr, `MB_F_INJECT);
               4'h1:    prog = mk(mbist_pkg::el_rwr, `MB_F_NONE);
               4'h2:    prog = mk(mbist_pkg::el_rw, `MB_F_DOWN | `MB_F_INV);
               4'h3:    prog = mk(mbist_pkg::el_rd, `MB_F_NONE);
               default: prog = mk(mbist_pkg::el_end, `MB_F_NONE);
            endcase
         end
         `MB_PAT_ROW_MARCH, `MB_PAT_COL_MARCH: begin
            case (idx)
               4'h0:    prog = mk(mbist_pkg::el_wr, yf);
               4'h1:    prog = mk(mbist_pkg::el_rwr, yf);
               4'h2:    prog = mk(mbist_pkg::el_rwr, yf | `MB_F_DOWN | `MB_F_INV);
               4'h3:    prog = mk(mbist_pkg::el_rd, yf);
               default: prog = mk(mbist_pkg::el_end, `MB_F_NONE);
            endcase
         end
         `MB_PAT_WL_RWR, `MB_PAT_BL_RWR: begin
            case (idx)
               4'h0:    prog = mk(mbist_pkg::el_wr, yf);
               4'h1:    prog = mk(mbist_pkg::el_rwr, yf);
               4'h2:    prog = mk(mbist_pkg::el_rwr, yf | `MB_F_DOWN | `MB_F_INV);
               default: prog = mk(mbist_pkg::el_end, `MB_F_NONE);
            endcase
         end
         `MB_PAT_HAMMER: begin
            case (idx)
               4'h0:    prog = mk(mbist_pkg::el_wr, `MB_F_NONE);
               4'h1:    prog = mk(mbist_pkg::el_bang, `MB_F_NONE);
               default: prog = mk(mbist_pkg::el_end, `MB_F_NONE);
            endcase
         end
         `MB_PAT_MARCH_CY: begin
            case (idx)
               4'h0:    prog = mk(mbist_pkg::el_wr, `MB_F_YFAST);
               4'h1:    prog = mk(mbist_pkg::el_rw, `MB_F_YFAST);
               4'h2:    prog = mk(mbist_pkg::el_rw, `MB_F_YFAST | `MB_F_INV);
               4'h3:    prog = mk(mbist_pkg::el_rw, `MB_F_YFAST | `MB_F_DOWN);
               4'h4:    prog = mk(mbist_pkg::el_rw, `MB_F_YFAST | `MB_F_DOWN | `MB_F_INV);
               4'h5:    prog = mk(mbist_pkg::el_rd, `MB_F_YFAST | `MB_F_DOWN);
               default: prog = mk(mbist_pkg::el_end, `MB_F_NONE);
            endcase
         end
         `MB_PAT_GO_NOGO: begin
            case (idx)
               4'h0, 4'h2: prog = mk(mbist_pkg::el_wr, `MB_F_CKBD | `MB_F_SEED5);
               4'h1, 4'h3: prog = mk(mbist_pkg::el_rd, `MB_F_CKBD | `MB_F_SEED5);
               4'h4:       prog = mk(mbist_pkg::el_wr, `MB_F_YFAST);
               4'h5:       prog = mk(mbist_pkg::el_rwr, `MB_F_YFAST);
               4'h6:       prog = mk(mbist_pkg::el_rwr, `MB_F_YFAST | `MB_F_DOWN | `MB_F_INV);
               4'h7:       prog = mk(mbist_pkg::el_wr, `MB_F_NONE);
               4'h8:       prog = mk(mbist_pkg::el_bang, `MB_F_NONE);
               default:    prog = mk(mbist_pkg::el_end, `MB_F_NONE);
            endcase
         end
         // Unknown codes end at once without touching the arrays
         default: prog = mk(mbist_pkg::el_end, `MB_F_NONE);
      endcase
   endfunction : prog
   // Sequencer state
   mbist_pkg::state_e     state_r, state_nxt;   // Engine state
   mbist_pkg::cfg_s       cfg_r;                // Configuration held for the run
   logic [5:0]            code_r;               // Latched pattern code
   logic [3:0]            elem_r, elem_nxt;     // Current element index
   logic [2:0]            op_r, op_nxt;         // Operation within a location
   logic [`MB_ADDR_W-1:0] cnt_r, cnt_nxt;       // Linear march counter
   logic [1:0]            drain_r, drain_nxt;   // Cycles left for the read pipe
   logic                  done_nxt;             // End-of-test pulse
   logic                  fail_nxt;             // Sticky mismatch flag
   // Compare pipeline
   logic                  cmp_pend_r;           // Read data due this cycle
   logic [`MB_BUS_W-1:0]  cmp_exp_r;            // Expected read data
   logic                  mismatch;             // Read data differs
   // Decode of the current element
   mbist_pkg::elem_s      cur;                  // Element being walked
   mbist_pkg::elem_s      nxt;                  // Element that follows
   logic [`MB_ADDR_W-1:0] amax;                 // Top address for the size
   logic [2:0]            op_last;              // Last operation index
   logic                  at_end;               // Counter at the element's far end
   logic [`MB_ADDR_W-1:0] lin_addr;             // Counter mapped to {row, col}
   logic                  is_bang_row;          // Hammer write to row 0
   logic [`MB_ADDR_W-1:0] iss_addr;             // Address issued this cycle
   logic                  running;              // An element is active
   logic                  iss_rd;               // Read issued this cycle
   logic                  iss_we;               // Write issued this cycle
   logic                  pol;                  // Data polarity for this access
   logic [3:0]            seed_use;             // Seed in force
   logic [63:0]           solid64;              // Seed replicated 16 times
   logic [24:0]           word;                 // Tag word, parity width
   logic [`MB_BUS_W-1:0]  wr_bus;               // Data for all CPUs
   logic [`MB_EN_W-1:0]   en_sel;               // One-hot array group select
   assign cur = prog(code_r, elem_r);
   assign nxt = prog(code_r, elem_r + 4'h1);
   // Top address per cache size: 128, 256 or 512 entries
   assign amax = (cfg_r.cache_size == `MB_SIZE_16K) ? `MB_AMAX_16K :
                 (cfg_r.cache_size == `MB_SIZE_32K) ? `MB_AMAX_32K : `MB_AMAX_64K;
   // Operations per location for each element kind
   assign op_last = (cur.kind == mbist_pkg::el_rwr)  ? `MB_LAST_RWR :
                    (cur.kind == mbist_pkg::el_rw)   ? `MB_LAST_RW :
                    (cur.kind == mbist_pkg::el_bang) ? `MB_LAST_BANG : 3'h0;
   assign at_end  = cur.down ? (cnt_r == '0) : (cnt_r == amax);
   mbist_addr_gen u_addr_gen (
      .cnt        (cnt_r),
      .cache_size (cfg_r.cache_size),
      .yfast      (cur.yfast),
      .addr       (lin_addr)
   );
   // Hammer writes after the first go to the same column in row 0
   assign is_bang_row = (cur.kind == mbist_pkg::el_bang) && (op_r >= `MB_BANG_FIRST_RW);
   assign iss_addr    = is_bang_row ? {7'h00, lin_addr[1:0]} : lin_addr;
   // First operation of a location reads except in write elements, middle ones write inverse
   assign running = (state_r == mbist_pkg::st_run) && (cur.kind != mbist_pkg::el_end);
   assign iss_rd  = running && ((cur.kind == mbist_pkg::el_rd) ||
                    ((cur.kind != mbist_pkg::el_wr) && (op_r == 3'h0)) ||
                    ((cur.kind == mbist_pkg::el_rwr) && (op_r == `MB_LAST_RWR)));
   assign iss_we  = running && !iss_rd;
   // Polarity: element inverse, flipped after the first op, checkerboard, injected fault
   assign pol = cur.inv ^ (op_r != 3'h0)
              ^ (cur.ckbd & (iss_addr[2] ^ iss_addr[0]))
              ^ (cur.inject & iss_we & (iss_addr[3:0] == `MB_INJECT_NIB));
   assign seed_use = cur.seed5 ? `MB_SEED_GO : cfg_r.seed;
   assign solid64  = {16{seed_use}};
   // Without parity the top three bits are cleared so the word is 22 bits
   assign word = cfg_r.parity ? (solid64[24:0] ^ {25{pol}})
                              : {3'h0, solid64[21:0] ^ {22{pol}}};
   // Per CPU: word for way 1/3 above word for way 0/2, each zero padded
   generate
      for (genvar g = 0; g < `MB_CPUS; g = g + 1) begin : g_cpu
         assign wr_bus[g*`MB_SLOT_W +: `MB_SLOT_W] = cfg_r.parity
            ? {11'h000, word, 11'h000, word}
            : {8'h00, 10'h000, word[21:0], 10'h000, word[21:0]};
      end
   endgenerate
   // Only the selected pair of ways is enabled during a run
   assign en_sel = cfg_r.way_group ? (18'h0_0001 << `MB_EN_HIGH_WAYS)
                                   : (18'h0_0001 << `MB_EN_LOW_WAYS);
   // Any difference in the returned bus, pad bits included, is a failure
   assign mismatch = cmp_pend_r && (test_read_data != cmp_exp_r);
   // Start clears the flag, but a mismatch in the same cycle still sets it
   assign fail_nxt = (fail & ~(start & (state_r == mbist_pkg::st_idle))) | mismatch;
   // Sequencer next state
   always_comb begin
      state_nxt = state_r;
      elem_nxt  = elem_r;
      op_nxt    = op_r;
      cnt_nxt   = cnt_r;
      drain_nxt = drain_r;
      done_nxt  = 1'h0;
      case (state_r)
         mbist_pkg::st_idle: begin
            // Requests while busy are ignored
            if (start) begin
               state_nxt = mbist_pkg::st_init;
               elem_nxt  = 4'h0;
               op_nxt    = 3'h0;
            end
         end
         mbist_pkg::st_init: begin
            // Code is latched now, so the first element's direction is known
            cnt_nxt   = cur.down ? amax : '0;
            state_nxt = mbist_pkg::st_run;
         end
         mbist_pkg::st_run: begin
            if (cur.kind == mbist_pkg::el_end) begin
               state_nxt = mbist_pkg::st_drain;
               drain_nxt = `MB_DRAIN_CYC;
            end else if (op_r != op_last) begin
               op_nxt = op_r + 3'h1;
            end else begin
               op_nxt = 3'h0;
               if (at_end) begin
                  // Each element restarts at 0 or at the top address
                  elem_nxt = elem_r + 4'h1;
                  cnt_nxt  = nxt.down ? amax : '0;
               end else begin
                  cnt_nxt = cur.down ? (cnt_r - 9'h001) : (cnt_r + 9'h001);
               end
            end
         end
         mbist_pkg::st_drain: begin
            // Let the last read reach the comparator before reporting
            if (drain_r == 2'h0) begin
               state_nxt = mbist_pkg::st_idle;
               done_nxt  = 1'h1;
            end else begin
               drain_nxt = drain_r - 2'h1;
            end
         end
         default: state_nxt = mbist_pkg::st_idle;
      endcase
   end
   // Sequencer registers
   always_ff @(posedge clk) begin
      if (reset) begin
         state_r <= mbist_pkg::st_idle;
         elem_r  <= 4'h0;
         op_r    <= 3'h0;
         cnt_r   <= '0;
         drain_r <= 2'h0;
         done    <= 1'h0;
         fail    <= 1'h0;
      end else begin
         state_r <= state_nxt;
         elem_r  <= elem_nxt;
         op_r    <= op_nxt;
         cnt_r   <= cnt_nxt;
         drain_r <= drain_nxt;
         done    <= done_nxt;
         fail    <= fail_nxt;
      end
   end
   // Pattern code and configuration are held for the whole run
   always_ff @(posedge clk) begin
      if (reset) begin
         code_r <= 6'h00;
         cfg_r  <= '0;
      end else if (start && (state_r == mbist_pkg::st_idle)) begin
         code_r <= test_instr[`MB_CODE_HI:`MB_CODE_LO];
         cfg_r  <= cfg;
      end
   end
   // Array side outputs, one cycle after issue
   always_ff @(posedge clk) begin
      if (reset) begin
         array_enable_bus <= '0;
         test_address_bus <= '0;
         test_write_data  <= '0;
         test_write_en    <= 1'h0;
         test_read_en     <= 1'h0;
      end else begin
         array_enable_bus <= (state_r == mbist_pkg::st_run) ? en_sel : '0;
         test_address_bus <= running ? iss_addr : '0;
         test_write_data  <= running ? wr_bus : '0;
         test_write_en    <= iss_we;
         test_read_en     <= iss_rd;
      end
   end
   // Read data returns one cycle after the read strobe; expected data follows it
   always_ff @(posedge clk) begin
      if (reset) begin
         cmp_pend_r <= 1'h0;
         cmp_exp_r  <= '0;
      end else begin
         cmp_pend_r <= test_read_en;
         cmp_exp_r  <= test_write_data;
      end
   end
   assign busy = (state_r != mbist_pkg::st_idle);
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   a_enable_ways: assert property ((|array_enable_bus) |->
      (array_enable_bus == en_sel) && $onehot(array_enable_bus))
      else $error("enable bus selects wrong array group");
   a_addr_limit: assert property (busy |-> (test_address_bus <= amax))
      else $error("address beyond array size");
   a_tag_width: assert property ((test_write_en && !cfg_r.parity) |->
      (test_write_data[24:22] == 3'h0))
      else $error("tag word wider than 22 bits without parity");
   a_pad_zero: assert property (test_write_en |-> (test_write_data[287:216] ==
      test_write_data[71:0]) && (cfg_r.parity ? (test_write_data[71:61] == 11'h000) &&
      (test_write_data[35:25] == 11'h000) : (test_write_data[71:54] == 18'h0_0000) &&
      (test_write_data[31:22] == 10'h000)))
      else $error("write data padding or per-CPU copy wrong");
   a_code_taken: assert property ((start && !busy) |=>
      (code_r == $past(test_instr[`MB_CODE_HI:`MB_CODE_LO])) && (state_r == mbist_pkg::st_init))
      else $error("pattern code not latched at start");
   a_solid_data: assert property ((iss_we && (code_r == `MB_PAT_SOLID_WR)) |=>
      (test_write_data[21:0] == solid64[21:0]) && test_write_en)
      else $error("solid write data wrong");
   a_ckbd_pol: assert property ((test_write_en && (code_r == `MB_PAT_CKBD_WR)) |->
      (test_write_data[0] == (cfg_r.seed[0] ^ test_address_bus[2] ^ test_address_bus[0])))
      else $error("checkerboard polarity wrong");
   a_march_turn: assert property ((state_r == mbist_pkg::st_run) && (code_r == `MB_PAT_MARCH_CP)
      && $changed(elem_r) && (elem_r == 4'h3) |-> (cnt_r == amax))
      else $error("descending march does not start at top address");
   a_inject_mark: assert property ((iss_we && (code_r == `MB_PAT_FAULT) && (elem_r == 4'h0)
      && (iss_addr[3:0] == `MB_INJECT_NIB)) |=> (test_write_data[0] != cfg_r.seed[0]))
      else $error("fault not injected at sixteenth address");
   a_bang_rows: assert property ((iss_we && is_bang_row) |=>
      test_write_en && (test_address_bus[8:2] == 7'h00))
      else $error("hammer write not in row 0");
   a_fail_set: assert property (mismatch |=> fail ##1 fail)
      else $error("mismatch not flagged");
   c_march_done: cover property (done && (code_r == `MB_PAT_MARCH_CP));
   c_fail_seen: cover property ($rose(fail));
   c_go_done: cover property (done && (code_r == `MB_PAT_GO_NOGO));
   c_bang_row: cover property (iss_we && is_bang_row);
endmodule : mbist_pattern_engine
`default_nettype wire

// >>> testbench/tag_ram_model.sv
`timescale 1ns/1ps
`default_nettype none
// Behavioural tag arrays of all CPUs: one whole bus word per address
module tag_ram_model (
   input  wire logic         clk,
   input  wire logic         wr,
   input  wire logic         rd,
   input  wire logic [8:0]   addr,
   input  wire logic [287:0] wdata,
   input  wire logic         flip,
   output logic      [287:0] rdata
);
   logic [287:0] mem [512]; // Storage, pad bits included
   // Read answers one cycle late; otherwise the bus shows the inverse of its
   // last value, so a stale word can never pass for a fresh one
   always @(posedge clk) begin
      if (wr) mem[addr] <= wdata;
      rdata <= rd ? mem[addr] ^ {288{flip}} : ~rdata; // Flip only when commanded
   end
endmodule : tag_ram_model
`default_nettype wire

// >>> testbench/mbist_pattern_engine_tb.sv
`timescale 1ns/1ps
`default_nettype none
module mbist_pattern_engine_tb;
   logic            clk = 0, reset = 1, start = 0, flip = 0;
   logic [55:0]     test_instr = '0;
   mbist_pkg::cfg_s cfg = '0;
   logic [287:0]    rdata, wdata;
   logic [17:0]     en;
   logic [8:0]      addr, maxa;
   logic            we, re, busy, done, fail;
   logic [5:0]      code = '0;
   int              miscompares = 0, checks = 0, accs = 0, n;
   int              op_tab [16] = '{1, 1, 1, 1, 14, 7, 8, 8, 7, 7, 9, 10, 0, 0, 0, 0};
   logic [5:0]      seq [16] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h01, 6'h06,
                                 6'h07, 6'h08, 6'h09, 6'h0A, 6'h0B, 6'h15, 6'h3F, 6'h00};
   always #2.5 clk = ~clk;
   mbist_pattern_engine DUT (.clk(clk), .reset(reset), .start(start), .test_instr(test_instr),
      .cfg(cfg), .test_read_data(rdata), .array_enable_bus(en), .test_address_bus(addr),
      .test_write_data(wdata), .test_write_en(we), .test_read_en(re), .busy(busy),
      .done(done), .fail(fail));
   tag_ram_model ram (.clk(clk), .wr(we), .rd(re), .addr(addr), .wdata(wdata),
      .flip(flip), .rdata(rdata));
   task check(string name, logic [287:0] seen, logic [287:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task print_verdict;
      if (miscompares == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : print_verdict
   // Whole bus for one tag word: pad zeros, two words per CPU, four CPUs
   function automatic logic [287:0] expw(logic [3:0] s, logic p, logic inv);
      logic [63:0] r;
      r = {16{s}} ^ {64{inv}};
      return {4{p ? {11'h0, r[24:0], 11'h0, r[24:0]} : {18'h0, r[21:0], 10'h0, r[21:0]}}};
   endfunction : expw
   // Accesses per location of each program; unknown codes make none
   function automatic int ops(logic [5:0] c);
      return c == 6'h3F ? 20 : c < 6'h10 ? op_tab[c[3:0]] : 0;
   endfunction : ops
   // Access monitor: counts, tracks top address, checks enables and write words
   always @(posedge clk) if (we || re) begin
      accs++;
      if (addr > maxa) maxa = addr;
      check("enable", 288'(en), 288'(18'h1 << (16 + cfg.way_group)));
      if (we && (code == 6'h00 || code == 6'h02)) // Solid or checkerboard writes only
         check("write word", wdata, expw(cfg.seed, cfg.parity, code[1] & (addr[2] ^ addr[0])));
   end
   // One test: random config unless reading back the previous one
   task automatic run(input logic [5:0] c, input logic efail);
      int k;
      k = 0;
      @(posedge clk);
      if (c != 6'h01 && c != 6'h03) cfg <= mbist_pkg::cfg_s'(8'($urandom));
      code <= c;
      test_instr <= {c, 50'($urandom)};
      start <= 1;
      accs = 0;
      maxa = '0;
      @(posedge clk) start <= 0;
      while (done !== 1'b1 && k < 12000) begin
         @(negedge clk);
         k++;
         if (k == 1) check("busy", 288'(busy), 288'(1));
      end
      check("busy at done", 288'(busy), 288'(0));
      n = cfg.cache_size == 2'h0 ? 128 : cfg.cache_size == 2'h1 ? 256 : 512;
      check("fail", 288'(fail), 288'(efail));
      check("accesses", 288'(accs), 288'(ops(c) * n));
      if (ops(c) > 0) check("top address", 288'(maxa), 288'(n - 1));
      else check("idle done", 288'(k), 288'(6)); // Taking edge's own negedge counts too
      if (k >= 12000) begin
         miscompares++;
         print_verdict;
      end
   endtask : run
   initial begin
      void'($urandom(32'ha00d));
      repeat (2) @(posedge clk);
      reset <= 0;
      foreach (seq[i]) run(seq[i], seq[i] == 6'h05);
      flip = 1; // Corrupt every read word to prove detection
      run(6'h01, 1'b1);
      print_verdict;
   end
endmodule : mbist_pattern_engine_tb
`default_nettype wire
